// [flic_pkg.sv]
// Purpose: Shared constants and types for the interrupt controller
// Assumes: APB register access, one clock
// Notes:   Source index equals fixed polling rank, 0 first
package flic_pkg;
    localparam int NUM_SRC   = 15;
    localparam int NUM_LVL   = 4;
    localparam int SRC_W     = 4;
    localparam int LVL_W     = 2;
    localparam int A_SRC     = 7;
    localparam int B_SRC     = 8;
    localparam int GATE_BIT  = 7;
    // Source positions of the two external inputs
    localparam logic [3:0] SRC_EXT_A = 4'h0;
    localparam logic [3:0] SRC_EXT_B = 4'h2;
    // Register byte offsets
    localparam logic [7:0] OFS_EN_A   = 8'h00;
    localparam logic [7:0] OFS_EN_B   = 8'h04;
    localparam logic [7:0] OFS_PL_A   = 8'h08;
    localparam logic [7:0] OFS_PH_A   = 8'h0C;
    localparam logic [7:0] OFS_PL_B   = 8'h10;
    localparam logic [7:0] OFS_PH_B   = 8'h14;
    localparam logic [7:0] OFS_TCTL   = 8'h18;
    localparam logic [7:0] OFS_STAT   = 8'h1C;
    localparam logic [7:0] OFS_PEND   = 8'h20;
    // Timer control field positions
    localparam int TC_TRIG_A = 0;
    localparam int TC_FLAG_A = 1;
    localparam int TC_TRIG_B = 2;
    localparam int TC_FLAG_B = 3;
    localparam logic [7:0] RST_BYTE = 8'h00;
    localparam logic [1:0] RST_PIN  = 2'h3;

    typedef struct packed {
        logic        psel;
        logic        penable;
        logic        pwrite;
        logic [7:0]  paddr;
        logic [31:0] pwdata;
    } flic_apb_req_t;

    typedef struct packed {
        logic             req;
        logic [SRC_W-1:0] vector;
        logic [LVL_W-1:0] level;
    } flic_cpu_req_t;
endpackage

// [flic_ctrl.sv]
// Purpose: Four-level nested interrupt controller with APB registers
// Assumes: CPU pulses ack when it takes a vector and reti when done
// Notes:   External pins are synchronised; pins idle high
// Notes on behaviour
// - Four distinct priority levels serviced
// - Fifteen request sources accepted
// - Per-source enable bit blocks interrupt
// - Global gate in enable A blocks all
// - Level from priority low/high bit pair
// - Preempt only by strictly higher level
// - Top-level routine never preempted
// - Equal-level ties resolved by fixed polling
// - Polling never overrides programmed levels
// - Two identical external inputs
// - Trigger-type bit selects level or edge
// - Edge mode: high then low sets flag
// - Enabled external request wakes processor
`timescale 1ns/10ps
module flic_ctrl
    import flic_pkg::*;
(
    input  wire logic                clk,
    input  wire logic                sys_rst,
    input  wire flic_apb_req_t       apb_req,
    output logic                     pready,
    output logic                     pslverr,
    output logic [31:0]              prdata,
    input  wire logic [NUM_SRC-1:0]  periph_irq,
    input  wire logic [1:0]          ext_request_pin,
    input  wire logic                cpu_ack,
    input  wire logic                cpu_reti,
    output flic_cpu_req_t            cpu_req,
    output logic                     wake_req
);
    typedef struct packed {
        logic [7:0]         irq_enable_reg_a;
        logic [7:0]         irq_enable_reg_b;
        logic [7:0]         prio_low_reg_a;
        logic [7:0]         prio_high_reg_a;
        logic [7:0]         prio_low_reg_b;
        logic [7:0]         prio_high_reg_b;
        logic [7:0]         timer_control_reg;
        logic [1:0]         pin_meta;
        logic [1:0]         pin_sync;
        logic [1:0]         pin_prev;
        logic [NUM_LVL-1:0] in_service;
        logic [31:0]        rdata;
        flic_cpu_req_t      cpu;
        logic               wake;
    } flic_state_t;

    flic_state_t s;
    flic_state_t next_s;

    logic [NUM_SRC-1:0] enable_vec;
    logic [NUM_SRC-1:0] plow_vec;
    logic [NUM_SRC-1:0] phigh_vec;
    logic [NUM_SRC-1:0] raw_req;
    logic [NUM_SRC-1:0] pending;
    logic [1:0]         ext_req;
    logic [1:0]         edge_seen;
    logic               global_irq_gate;
    logic               found;
    logic [SRC_W-1:0]   best_idx;
    logic [LVL_W-1:0]   best_lvl;
    logic               any_active;
    logic [LVL_W-1:0]   active_lvl;
    logic               preempt_ok;
    logic               setup;
    logic               wr_take;
    logic               mapped;
    logic [31:0]        rd_mux;
    logic [LVL_W-1:0]   lvl_i;
    logic [3:0]         ack_mask;
    logic [3:0]         reti_mask;

    // Source enables and levels spread over two register pairs
    assign enable_vec = {s.irq_enable_reg_b,
                         s.irq_enable_reg_a[A_SRC-1:0]};
    assign plow_vec   = {s.prio_low_reg_b,
                         s.prio_low_reg_a[A_SRC-1:0]};
    assign phigh_vec  = {s.prio_high_reg_b,
                         s.prio_high_reg_a[A_SRC-1:0]};
    assign global_irq_gate = s.irq_enable_reg_a[GATE_BIT];

    assign edge_seen = s.pin_prev & ~s.pin_sync;

    assign ext_req[0] = s.timer_control_reg[TC_TRIG_A] ?
                        s.timer_control_reg[TC_FLAG_A] : ~s.pin_sync[0];
    assign ext_req[1] = s.timer_control_reg[TC_TRIG_B] ?
                        s.timer_control_reg[TC_FLAG_B] : ~s.pin_sync[1];

    always_comb begin
        raw_req = periph_irq;
        raw_req[SRC_EXT_A] = ext_req[0];
        raw_req[SRC_EXT_B] = ext_req[1];
    end

    assign pending = raw_req & enable_vec & {NUM_SRC{global_irq_gate}};

    // Highest level first, lowest index within a level
    always_comb begin
        found    = 1'b0;
        best_idx = '0;
        best_lvl = '0;
        lvl_i    = '0;
        for (int i = 0; i < NUM_SRC; i++) begin
            lvl_i = {phigh_vec[i], plow_vec[i]};
            if (pending[i]) begin
                if (!found || lvl_i > best_lvl) begin
                    found    = 1'b1;
                    best_idx = i[SRC_W-1:0];
                    best_lvl = lvl_i;
                end
                // Lower index kept on equal level
            end
        end
    end

    always_comb begin
        any_active = |s.in_service;
        active_lvl = '0;
        for (int l = 0; l < NUM_LVL; l++) begin
            if (s.in_service[l]) begin
                active_lvl = l[LVL_W-1:0];
            end
        end
    end

    assign preempt_ok = found && (!any_active || best_lvl > active_lvl);

    always_comb begin
        ack_mask  = '0;
        reti_mask = '0;
        ack_mask[s.cpu.level] = cpu_ack & s.cpu.req;
        for (int l = 0; l < NUM_LVL; l++) begin
            if (s.in_service[l]) begin
                reti_mask = '0;
                reti_mask[l] = cpu_reti;
            end
        end
    end

    // APB decode; zero wait states, data staged in setup
    assign setup   = apb_req.psel & ~apb_req.penable;
    assign wr_take = apb_req.psel & apb_req.penable & apb_req.pwrite;

    always_comb begin
        mapped = 1'b1;
        rd_mux = '0;
        case (apb_req.paddr)
            OFS_EN_A: rd_mux[7:0] = s.irq_enable_reg_a;
            OFS_EN_B: rd_mux[7:0] = s.irq_enable_reg_b;
            OFS_PL_A: rd_mux[7:0] = s.prio_low_reg_a;
            OFS_PH_A: rd_mux[7:0] = s.prio_high_reg_a;
            OFS_PL_B: rd_mux[7:0] = s.prio_low_reg_b;
            OFS_PH_B: rd_mux[7:0] = s.prio_high_reg_b;
            OFS_TCTL: rd_mux[7:0] = s.timer_control_reg;
            OFS_STAT: begin
                rd_mux[3:0] = s.in_service;
                rd_mux[7:4] = s.cpu.vector;
                rd_mux[9:8] = s.cpu.level;
                rd_mux[10]  = s.cpu.req;
                rd_mux[11]  = s.wake;
            end
            OFS_PEND: rd_mux[NUM_SRC-1:0] = pending;
            default:  mapped = 1'b0;
        endcase
    end

    assign pready  = 1'b1;
    assign pslverr = apb_req.psel & apb_req.penable & ~mapped;
    assign prdata  = s.rdata;
    assign cpu_req = s.cpu;
    assign wake_req = s.wake;

    always_comb begin
        next_s = s;
        // Only pin_sync reads pin_meta
        next_s.pin_meta = ext_request_pin;
        next_s.pin_sync = s.pin_meta;
        next_s.pin_prev = s.pin_sync;
        if (setup && !apb_req.pwrite) begin
            next_s.rdata = rd_mux;
        end
        if (wr_take && mapped) begin
            case (apb_req.paddr)
                OFS_EN_A: next_s.irq_enable_reg_a = apb_req.pwdata[7:0];
                OFS_EN_B: next_s.irq_enable_reg_b = apb_req.pwdata[7:0];
                OFS_PL_A: next_s.prio_low_reg_a   = apb_req.pwdata[7:0];
                OFS_PH_A: next_s.prio_high_reg_a  = apb_req.pwdata[7:0];
                OFS_PL_B: next_s.prio_low_reg_b   = apb_req.pwdata[7:0];
                OFS_PH_B: next_s.prio_high_reg_b  = apb_req.pwdata[7:0];
                OFS_TCTL: next_s.timer_control_reg = apb_req.pwdata[7:0];
                default: begin
                end
            endcase
        end
        // Vector fetch clears an edge flag
        if (cpu_ack && s.cpu.req) begin
            if (s.cpu.vector == SRC_EXT_A) begin
                next_s.timer_control_reg[TC_FLAG_A] = 1'b0;
            end
            if (s.cpu.vector == SRC_EXT_B) begin
                next_s.timer_control_reg[TC_FLAG_B] = 1'b0;
            end
        end
        // Edge flag set
        // Set last so an edge beats a same-cycle clear
        if (edge_seen[0] && s.timer_control_reg[TC_TRIG_A]) begin
            next_s.timer_control_reg[TC_FLAG_A] = 1'b1;
        end
        if (edge_seen[1] && s.timer_control_reg[TC_TRIG_B]) begin
            next_s.timer_control_reg[TC_FLAG_B] = 1'b1;
        end
        next_s.in_service = (s.in_service & ~reti_mask) | ack_mask;
        // Drop request right after ack; stack update is then visible
        next_s.cpu.req    = preempt_ok & ~cpu_ack & ~cpu_reti;
        next_s.cpu.vector = best_idx;
        next_s.cpu.level  = best_lvl;
        next_s.wake = |(ext_req & {enable_vec[SRC_EXT_B],
                                   enable_vec[SRC_EXT_A]})
                      & global_irq_gate;
    end

    always_ff @(posedge clk) begin
        if (sys_rst) begin
            s.irq_enable_reg_a  <= RST_BYTE;
            s.irq_enable_reg_b  <= RST_BYTE;
            s.prio_low_reg_a    <= RST_BYTE;
            s.prio_high_reg_a   <= RST_BYTE;
            s.prio_low_reg_b    <= RST_BYTE;
            s.prio_high_reg_b   <= RST_BYTE;
            s.timer_control_reg <= RST_BYTE;
            s.pin_meta          <= RST_PIN;
            s.pin_sync          <= RST_PIN;
            s.pin_prev          <= RST_PIN;
            s.in_service        <= '0;
            s.rdata             <= '0;
            s.cpu               <= '0;
            s.wake              <= 1'b0;
        end else begin
            s <= next_s;
        end
    end
endmodule // flic_ctrl

// [flic_ctrl_props.sv]
// Purpose: Port checker for the interrupt controller
// Assumes: CPU acks only while a request is shown
// Notes:   Helpers shadow enables and in-service levels
`timescale 1ns/10ps
module flic_ctrl_props
    import flic_pkg::*;
(
    input wire logic               clk,
    input wire logic               sys_rst,
    input wire flic_apb_req_t      apb_req,
    input wire logic               pready,
    input wire logic               pslverr,
    input wire logic [31:0]        prdata,
    input wire logic [NUM_SRC-1:0] periph_irq,
    input wire logic [1:0]         ext_request_pin,
    input wire logic               cpu_ack,
    input wire logic               cpu_reti,
    input wire flic_cpu_req_t      cpu_req,
    input wire logic               wake_req
);
    logic [15:0] en;
    logic [15:0] en_d;
    logic [3:0]  isv;
    logic [1:0]  top;
    logic        wr;
    assign wr = apb_req.psel && apb_req.penable && apb_req.pwrite;
    assign top = isv[3] ? 2'h3 : isv[2] ? 2'h2 : {1'b0, isv[1]};
    // Request is registered, so it sees enables one cycle late
    always_ff @(posedge clk) begin
        if (sys_rst) begin
            en   <= '0;
            en_d <= '0;
            isv  <= '0;
        end else begin
            en_d <= en;
            if (wr && apb_req.paddr == OFS_EN_A)
                en <= {apb_req.pwdata[7], en[14:7], apb_req.pwdata[6:0]};
            if (wr && apb_req.paddr == OFS_EN_B)
                en <= {en[15], apb_req.pwdata[7:0], en[6:0]};
            // Same-cycle ack and return: the ack's level stays set
            if (cpu_reti)
                isv[top] <= 1'b0;
            if (cpu_ack && cpu_req.req)
                isv[cpu_req.level] <= 1'b1;
        end
    end
    default clocking cb @(posedge clk); endclocking
    default disable iff (sys_rst);
    a_src_enable: assert property (
        $rose(cpu_req.req) |-> en_d[cpu_req.vector] && en_d[15])
        else $error("request from a disabled source");
    a_gate_quiet: assert property (
        !en[15] && !cpu_req.req |=> !cpu_req.req)
        else $error("request while gate closed");
    a_gate_wake: assert property (!en[15] |=> !wake_req)
        else $error("wake while gate closed");
    a_preempt_lvl: assert property (
        cpu_req.req |-> isv == 4'h0 || cpu_req.level > top)
        else $error("request not above active level");
    a_ack_drop: assert property (
        cpu_ack && cpu_req.req |=> !cpu_req.req)
        else $error("request kept after ack");
    a_reti_drop: assert property (cpu_reti |=> !cpu_req.req)
        else $error("request kept after return");
    a_req_stands: assert property (
        cpu_req.req && !cpu_ack && !cpu_reti |=> cpu_req.req)
        else $error("request withdrawn unasked");
    a_vec_range: assert property (
        cpu_req.req |-> cpu_req.vector <= 4'hE)
        else $error("vector out of range");
endmodule // flic_ctrl_props

// [flic_cpu_model.sv]
// Purpose: CPU side model that takes vectors
// Assumes: ack_dly idle cycles before each ack
// Notes:   Return pulse follows reti_go by one cycle
`timescale 1ns/10ps
module flic_cpu_model
    import flic_pkg::*;
(
    input  wire logic          clk,
    input  wire logic          sys_rst,
    input  wire flic_cpu_req_t cpu_req,
    input  wire logic [3:0]    ack_dly,
    input  wire logic          reti_go,
    output logic               cpu_ack,
    output logic               cpu_reti,
    output logic [3:0]         taken_vec,
    output logic [1:0]         taken_lvl,
    output logic [7:0]         taken_cnt
);
    logic [3:0] wait_cnt;
    always_ff @(posedge clk) begin
        cpu_reti <= reti_go && !sys_rst;
        cpu_ack  <= 1'b0;
        // Vector may move before the ack lands; take what stands then
        if (sys_rst) begin
            taken_cnt <= 8'h00;
        end else if (cpu_ack && cpu_req.req) begin
            taken_vec <= cpu_req.vector;
            taken_lvl <= cpu_req.level;
            taken_cnt <= taken_cnt + 8'h01;
        end
        if (sys_rst || !cpu_req.req || cpu_ack) begin
            wait_cnt <= 4'h0;
        end else if (wait_cnt == ack_dly) begin
            cpu_ack <= 1'b1;
        end else begin
            wait_cnt <= wait_cnt + 4'h1;
        end
    end
endmodule // flic_cpu_model

// [flic_ctrl_tb.sv]
// Purpose: Self-checking bench for the interrupt controller
// Assumes: CPU model acks each request
// Notes:   Every scenario starts from reset
`timescale 1ns/10ps
module flic_ctrl_tb
    import flic_pkg::*;
;
    logic          clk, sys_rst, pready, pslverr, ack, reti, wake;
    logic          reti_go, er;
    flic_apb_req_t apb;
    flic_cpu_req_t req;
    logic [31:0]   prdata, rd;
    logic [14:0]   irq;
    logic [1:0]    pin, tl;
    logic [3:0]    tv, dly;
    logic [7:0]    tc, c0;
    int            error_cnt, checked;
    flic_ctrl u_dut (.clk(clk), .sys_rst(sys_rst), .apb_req(apb),
        .pready(pready), .pslverr(pslverr), .prdata(prdata),
        .periph_irq(irq), .ext_request_pin(pin), .cpu_ack(ack),
        .cpu_reti(reti), .cpu_req(req), .wake_req(wake));
    flic_cpu_model u_cpu (.clk(clk), .sys_rst(sys_rst), .cpu_req(req),
        .ack_dly(dly), .reti_go(reti_go), .cpu_ack(ack),
        .cpu_reti(reti), .taken_vec(tv), .taken_lvl(tl), .taken_cnt(tc));
    initial begin
        clk = 1'b0;
        forever #10 clk = ~clk;
    end
    task automatic chk(input string n, input logic [31:0] e, g);
        checked++;
        if (g !== e) begin
            error_cnt++;
            $display("unexpected %s exp %h got %h", n, e, g);
        end
    endtask
    task automatic print_verdict();
        $display("errors %0d checks %0d", error_cnt, checked);
        if (error_cnt == 0 && checked > 0)
            $display("Run complete: PASS");
        else
            $display("Run complete: FAIL");
        $finish;
    endtask
    task automatic fail_out();
        error_cnt++;
        print_verdict();
    endtask
    task automatic bus(input logic w, input logic [7:0] a,
        input logic [31:0] d, output logic [31:0] q, output logic e);
        apb <= '{1'b1, 1'b0, w, a, d};
        @(posedge clk);
        apb.penable <= 1'b1;
        @(posedge clk);
        for (int n = 0; pready !== 1'b1; n++) begin
            if (n > 8) fail_out();
            @(posedge clk);
        end
        q = prdata;
        e = pslverr;
        apb <= '0;
        @(posedge clk);
    endtask
    task automatic wr(input logic [7:0] a, input logic [31:0] d);
        bus(1'b1, a, d, rd, er);
    endtask
    task automatic prog(input logic g, input logic [14:0] en, lo, hi);
        wr(OFS_EN_A, {24'h0, g, en[6:0]});
        wr(OFS_EN_B, {24'h0, en[14:7]});
        wr(OFS_PL_A, {25'h0, lo[6:0]});
        wr(OFS_PH_A, {25'h0, hi[6:0]});
        wr(OFS_PL_B, {24'h0, lo[14:7]});
        wr(OFS_PH_B, {24'h0, hi[14:7]});
    endtask
    task automatic take(input logic [3:0] v, input logic [1:0] l);
        c0 = tc;
        for (int n = 0; tc == c0; n++) begin
            if (n > 40) fail_out();
            @(posedge clk);
        end
        chk("vector", {28'h0, v}, {28'h0, tv});
        chk("level", {30'h0, l}, {30'h0, tl});
    endtask
    task automatic none();
        c0 = tc;
        repeat (20) @(posedge clk);
        chk("taken count", {24'h0, c0}, {24'h0, tc});
    endtask
    task automatic ret();
        reti_go <= 1'b1;
        @(posedge clk);
        reti_go <= 1'b0;
        @(posedge clk);
    endtask
    task automatic do_reset();
        sys_rst <= 1'b1;
        irq     <= '0;
        pin     <= 2'h3;
        repeat (10) @(posedge clk);
        sys_rst <= 1'b0;
        @(posedge clk);
    endtask
    task automatic s_reg();
        do_reset();
        for (int i = 0; i < 9; i++) begin
            bus(1'b0, 8'(i * 4), 32'h0, rd, er);
            chk("reset value", 32'h0, rd);
        end
        bus(1'b0, 8'h24, 32'h0, rd, er);
        chk("unmapped error", 32'h1, {31'h0, er});
        wr(OFS_EN_B, 32'h0000_00A5);
        bus(1'b0, OFS_EN_B, 32'h0, rd, er);
        chk("enable B", 32'h0000_00A5, rd);
    endtask
    task automatic s_prio();
        do_reset();
        dly <= 4'h3;
        prog(1'b1, 15'h7FFF, 15'h3060, 15'h3200);
        irq <= 15'h0270;
        take(4'h9, 2'h2);
        irq <= 15'h1070;
        take(4'hC, 2'h3);
        irq <= 15'h2070;
        none();
        ret();
        take(4'hD, 2'h3);
        irq <= 15'h0070;
        ret();
        ret();
        take(4'h5, 2'h1);
        irq <= 15'h0050;
        none();
        ret();
        take(4'h6, 2'h1);
        irq <= 15'h0010;
        ret();
        take(4'h4, 2'h0);
        irq <= '0;
        dly <= 4'h0;
    endtask
    task automatic s_gate();
        do_reset();
        prog(1'b0, 15'h0009, 15'h0, 15'h0);
        irq <= 15'h0008;
        pin <= 2'h2;
        none();
        chk("wake", 32'h0, {31'h0, wake});
        // Gate opened last so the ack cannot land inside the setup
        prog(1'b0, 15'h0001, 15'h0, 15'h0);
        wr(OFS_EN_A, 32'h0000_0081);
        take(4'h0, 2'h0);
        chk("wake", 32'h1, {31'h0, wake});
        bus(1'b0, OFS_PEND, 32'h0, rd, er);
        chk("pending", 32'h0000_0001, rd);
        bus(1'b0, OFS_STAT, 32'h0, rd, er);
        chk("status", 32'h0000_0801, rd);
        pin <= 2'h3;
        ret();
        none();
    endtask
    task automatic s_ext();
        do_reset();
        prog(1'b0, 15'h0005, 15'h0, 15'h0004);
        wr(OFS_TCTL, 32'h0000_0005);
        pin <= 2'h1;
        repeat (10) @(posedge clk);
        bus(1'b0, OFS_TCTL, 32'h0, rd, er);
        chk("edge flag", 32'h0000_000D, rd);
        wr(OFS_EN_A, 32'h0000_0085);
        take(4'h2, 2'h2);
        bus(1'b0, OFS_TCTL, 32'h0, rd, er);
        chk("flag cleared", 32'h0000_0005, rd);
        ret();
        none();
        pin <= 2'h0;
        take(4'h0, 2'h0);
        // Input B in level mode; its pin is still low
        wr(OFS_TCTL, 32'h0000_0001);
        take(4'h2, 2'h2);
    endtask
    initial begin
        sys_rst   = 1'b1;
        apb       = '0;
        irq       = '0;
        pin       = 2'h3;
        reti_go   = 1'b0;
        dly       = 4'h0;
        error_cnt = 0;
        checked   = 0;
        s_reg();
        s_prio();
        s_gate();
        s_ext();
        print_verdict();
    end
endmodule // flic_ctrl_tb

bind flic_ctrl flic_ctrl_props u_props (.clk(clk), .sys_rst(sys_rst),
    .apb_req(apb_req), .pready(pready), .pslverr(pslverr),
    .prdata(prdata), .periph_irq(periph_irq),
    .ext_request_pin(ext_request_pin), .cpu_ack(cpu_ack),
    .cpu_reti(cpu_reti), .cpu_req(cpu_req), .wake_req(wake_req));
